// File: verif/backlight_level_fault_supervisor_tb.sv
// testbench: supervisor level, fault and register checks
`timescale 1ns/1ns
`default_nettype none
module backlight_level_fault_supervisor_tb;
  import blfs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] aw_addr = 8'h00;
  logic [7:0] ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0;
  logic aw_valid = 1'b0;
  logic w_valid = 1'b0;
  logic b_ready = 1'b0;
  logic ar_valid = 1'b0;
  logic r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, irq;
  logic [1:0] b_resp, r_resp, lvl, gain;
  logic [31:0] r_data;
  logic [7:0] sensor = 8'hff;
  logic [6:0] needs = 7'h00;
  logic [6:0] sen = 7'h7f;
  logic pump, sinks, lowc;
  blfs_analog_t analog;
  int rail_mv = 0;
  int vin_mv = 3600;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] d;
  logic [1:0] rsp;
  int t;

  // clock at 100 mhz
  always #5 core_clk = ~core_clk;

  blfs_rail_model u_blfs_rail_model (.rail_mv(rail_mv), .vin_mv(vin_mv),
    .analog(analog));
  blfs_top #(.STEP_CYC(10), .MASK_WAIT(20), .SOFT_WAIT(5)) u_blfs_top (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
    .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
    .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .analog_in(analog),
    .sensor_reading(sensor), .sink_needs_gain(needs), .sink_enable(sen),
    .backlight_level_select(lvl), .pump_enable(pump),
    .sinks_enable(sinks), .low_current(lowc), .pump_gain(gain), .irq(irq));

  // compare one value
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // axi4-lite write, waits for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit done;
    int k;
    done = 0;
    @(posedge core_clk);
    aw_addr <= a;
    w_data <= v;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (k = 0; k < 100 && !done; k++) begin
      @(posedge core_clk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_ready && b_valid) begin
        done = 1;
        rsp = b_resp;
        b_ready <= 1'b0;
      end
    end
    if (!done) chk("write response", 1, 0);
  endtask

  // axi4-lite read into d and rsp
  task automatic rd(input logic [7:0] a);
    bit done;
    int k;
    done = 0;
    @(posedge core_clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (k = 0; k < 100 && !done; k++) begin
      @(posedge core_clk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_ready && r_valid) begin
        done = 1;
        d = r_data;
        rsp = r_resp;
        r_ready <= 1'b0;
      end
    end
    if (!done) chk("read response", 1, 0);
  endtask

  // reset values and an unmapped read
  task automatic t_reset;
    chk("low current", 1, lowc);
    chk("pump", 0, pump);
    rd(ADDR_CTRL);
    chk("ctrl", CTRL_RST, d);
    rd(8'h40);
    chk("unmapped resp", 2'b10, rsp);
    chk("unmapped data", 0, d);
    wr(8'h40, 32'h0000_0001);
    chk("unmapped write resp", 2'b10, rsp);
    $display("test reset done");
  endtask

  // automatic level from the two flags
  task automatic t_auto;
    wr(ADDR_FILT, 32'h0);
    chk("write resp", 2'b00, rsp);
    wr(ADDR_OTRP, 32'h1080);
    wr(ADDR_DTRP, 32'h0840);
    // host level 01 must be overridden by the flags once auto is on
    wr(ADDR_CTRL, 32'h12);
    chk("level day", LVL_DAY, lvl);
    @(posedge core_clk);
    sensor <= 8'h70;
    repeat (5) @(posedge core_clk);
    chk("filtered level", LVL_DAY, lvl);
    for (t = 0; t < 80 && lvl !== LVL_OFFICE; t++) @(posedge core_clk);
    chk("level office", LVL_OFFICE, lvl);
    rd(ADDR_STAT);
    chk("cmp flag", 1, d[ST_CMP]);
    sensor <= 8'h30;
    for (t = 0; t < 80 && lvl !== LVL_DARK; t++) @(posedge core_clk);
    chk("level dark", LVL_DARK, lvl);
    rd(ADDR_SENS);
    chk("both flags", 2'b11, d[1:0]);
    sensor <= 8'h88;
    for (t = 0; t < 80 && lvl === LVL_DARK; t++) @(posedge core_clk);
    for (t = 0; t < 40 && lvl === LVL_OFFICE; t++) @(posedge core_clk);
    chk("office hysteresis", LVL_OFFICE, lvl);
    sensor <= 8'ha0;
    for (t = 0; t < 80 && lvl !== LVL_DAY; t++) @(posedge core_clk);
    chk("back to day", LVL_DAY, lvl);
    wr(ADDR_STAT, 32'h1);
    rd(ADDR_STAT);
    chk("cmp cleared", 0, d[ST_CMP]);
    sensor <= 8'h30;
    wr(ADDR_CTRL, 32'h10);
    repeat (3) @(posedge core_clk);
    chk("manual office", LVL_OFFICE, lvl);
    wr(ADDR_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("manual day", LVL_DAY, lvl);
    $display("test auto level done");
  endtask

  // short entry, mask window, interrupt and restart
  task automatic t_short;
    wr(ADDR_STAT, 32'h7);
    wr(ADDR_MASK, 32'h4);
    wr(ADDR_CTRL, 32'h1);
    repeat (8) @(posedge core_clk);
    chk("masked short", 0, lowc);
    for (t = 0; t < 100 && lowc !== 1'b1; t++) @(posedge core_clk);
    chk("short state", 1, lowc);
    for (t = 0; t < 10 && irq !== 1'b1; t++) @(posedge core_clk);
    chk("irq raised", 1, irq);
    @(posedge core_clk);
    rail_mv <= 4000;
    wr(ADDR_STAT, 32'h0);
    rd(ADDR_STAT);
    chk("short held", 1, d[ST_SHORT]);
    wr(ADDR_MASK, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("irq masked", 0, irq);
    wr(ADDR_MASK, 32'h4);
    wr(ADDR_STAT, 32'h4);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", 0, irq);
    wr(ADDR_CTRL, 32'h1);
    for (t = 0; t < 100 && sinks !== 1'b1; t++) @(posedge core_clk);
    chk("restarted", 1, sinks);
    chk("normal current", 0, lowc);
    $display("test short done");
  endtask

  // overvoltage entry, hysteresis, repeat and clamp
  task automatic t_ovp;
    @(posedge core_clk);
    rail_mv <= 6000;
    for (t = 0; t < 40 && pump !== 1'b0; t++) @(posedge core_clk);
    chk("pump off", 0, pump);
    chk("sinks on", 1, sinks);
    rd(ADDR_STAT);
    chk("ovp flag", 1, d[ST_OVP]);
    wr(ADDR_STAT, 32'h2);
    rail_mv <= 5500;
    repeat (20) @(posedge core_clk);
    chk("pump held off", 0, pump);
    rail_mv <= 5200;
    for (t = 0; t < 40 && pump !== 1'b1; t++) @(posedge core_clk);
    chk("pump back", 1, pump);
    rail_mv <= 6000;
    for (t = 0; t < 40 && pump !== 1'b0; t++) @(posedge core_clk);
    rd(ADDR_STAT);
    chk("ovp again", 1, d[ST_OVP]);
    wr(ADDR_STAT, 32'h2);
    rail_mv <= 4950;
    repeat (20) @(posedge core_clk);
    rd(ADDR_STAT);
    chk("clamp silent", 0, d[2:0]);
    $display("test overvoltage done");
  endtask

  // gain up, down, and blocked step-down
  task automatic t_gain;
    @(posedge core_clk);
    needs <= 7'h08;
    for (t = 0; t < 20 && gain !== GAIN_2X; t++) @(posedge core_clk);
    chk("gain up", GAIN_2X, gain);
    needs <= 7'h00;
    for (t = 0; t < 20 && gain !== GAIN_1X; t++) @(posedge core_clk);
    chk("gain down", GAIN_1X, gain);
    wr(ADDR_CTRL, 32'h5);
    needs <= 7'h08;
    for (t = 0; t < 20 && gain !== GAIN_2X; t++) @(posedge core_clk);
    needs <= 7'h00;
    repeat (20) @(posedge core_clk);
    chk("gain held", GAIN_2X, gain);
    $display("test gain done");
  endtask

  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_auto();
    t_short();
    t_ovp();
    t_gain();
    finish_test();
  end

  // watchdog
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire

// File: verif/blfs_rail_model.sv
// model: analog rail comparators that feed the supervisor
`timescale 1ns/1ns
`default_nettype none
module blfs_rail_model
  import blfs_pkg::*;
(
  input var int rail_mv,
  input var int vin_mv,
  output var blfs_analog_t analog
);
  // comparator levels from rail and supply in millivolts
  always_comb begin
    analog.rail_low = (rail_mv * 100) < (vin_mv * 55);
    analog.rail_ovp = rail_mv > 5800;
    analog.rail_ovp_rel = rail_mv < 5300;
    analog.rail_clamp = rail_mv >= 4900;
  end
endmodule
`default_nettype wire

// File: verilog/blfs_pkg.sv
// package: constants and types for the backlight level and fault supervisor
// Overview of operation
// - Setting the auto level enable bit hands the level field to the level logic, driven by the two flags.
// - In auto mode the level is 00 with both flags clear and 01 with only the office flag set.
// - In auto mode a set dark flag forces level 10 whatever the office flag says.
// - With auto off the host writes any level directly and the flags are ignored.
// - A programmable filter time of 80 ms to 10 s, held in the filter register, delays every flag change.
// - With the step-down block bit set the pump gain never falls once raised, except to 1x on standby or on a short.
// - Gain is chosen over the enabled sinks of the seven and only falls when demanding sinks stop, on standby or on a short.
// - An output rail below 55 percent of supply enters short protection, low current, and sets its flag.
// - Short sensing is masked at start and on each restart, unmasked 4 ms later.
// - After a short the host restarts by writing active to 1 again, and a full soft start runs.
// - Reaching the 4.9 V clamp is regulated silently, with no flag.
// - Above about 5.8 V only the charge pump stops; sinks and the rest keep running.
// - The pump resumes when the rail falls to about 5.3 V and may trip again.
// - Every separate overvoltage entry sets the overvoltage flag.
// - The office flag sets below trip and clears only above trip plus hysteresis.
// - Writing 1 to a status flag clears it; reading or writing 0 leaves it.
package blfs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_FILT = 8'h6c;
  localparam logic [7:0] ADDR_OTRP = 8'h74;
  localparam logic [7:0] ADDR_DTRP = 8'h7c;
  localparam logic [7:0] ADDR_SENS = 8'h10;
  // control bit positions
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_GDB = 2;
  localparam int CTRL_LVL = 4;
  // status bit positions
  localparam int ST_CMP = 0;
  localparam int ST_OVP = 1;
  localparam int ST_SHORT = 2;
  localparam int NUM_EVT = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FILT_RST = 32'h0000_0000;
  localparam logic [31:0] TRP_RST = 32'h0000_0000;
  // times
  localparam int CLK_MHZ = 100;
  localparam int FILT_STEP_MS = 80;
  localparam int FILT_STEP_CYC = FILT_STEP_MS * CLK_MHZ * 1000;
  localparam int FILT_MAX_STEPS = 125;
  localparam int MASK_MS = 4;
  localparam int MASK_CYC = MASK_MS * CLK_MHZ * 1000;
  localparam int SOFT_US = 100;
  localparam int SOFT_CYC = SOFT_US * CLK_MHZ;
  localparam logic [1:0] LVL_DAY = 2'h0;
  localparam logic [1:0] LVL_OFFICE = 2'h1;
  localparam logic [1:0] LVL_DARK = 2'h2;
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_2X = 2'h2;
  typedef enum logic [1:0] {
    BLFS_OFF = 2'b00, BLFS_SOFT = 2'b01, BLFS_RUN = 2'b11, BLFS_SHORT = 2'b10
  } blfs_state_t;
  // analog indications, grouped
  typedef struct packed {
    logic rail_low;
    logic rail_ovp;
    logic rail_ovp_rel;
    logic rail_clamp;
  } blfs_analog_t;
endpackage

// File: verilog/blfs_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module blfs_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_dout;
  // second and third stages must agree before a change counts
  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// File: verilog/blfs_top.sv
// module: backlight level and fault supervisor with axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
module blfs_top
  import blfs_pkg::*;
#(
  parameter int STEP_CYC = FILT_STEP_CYC,
  parameter int MASK_WAIT = MASK_CYC,
  parameter int SOFT_WAIT = SOFT_CYC,
  parameter int NSINK = 7
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire blfs_analog_t analog_in,
  input wire logic [7:0] sensor_reading,
  input wire logic [NSINK-1:0] sink_needs_gain,
  input wire logic [NSINK-1:0] sink_enable,
  output logic [1:0] backlight_level_select,
  output logic pump_enable,
  output logic sinks_enable,
  output logic low_current,
  output logic [1:0] pump_gain,
  output logic irq
);
  // registers
  logic [31:0] ctrl, stat, mask, filt, otrp, dtrp;
  logic [31:0] next_ctrl, next_stat, next_mask, next_filt, next_otrp;
  logic [31:0] next_dtrp;
  logic aw_hold, w_hold;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
  logic [7:0] next_aw_a;
  logic [31:0] next_w_d, next_rdata;
  logic [3:0] next_w_s;
  logic [1:0] next_bresp, next_rresp;
  logic wr_go, act_write;
  blfs_analog_t an;
  // comparator / filter
  logic office_threshold_flag, dark_threshold_flag;
  logic next_office, next_dark, raw_office, raw_dark;
  logic [31:0] fcnt_o, fcnt_d, next_fcnt_o, next_fcnt_d, fwait;
  logic [1:0] next_level;
  // fault fsm
  blfs_state_t st, next_st;
  logic [31:0] tcnt, next_tcnt;
  logic ovp_on, next_ovp_on, next_pump, next_sinks, next_low;
  logic [1:0] next_gain;
  logic ev_short, ev_ovp, ev_cmp, next_irq;

  // pin synchronisers for all analog indications
  blfs_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .din(analog_in),
    .dout(an)
  );

  function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_MASK ||
      a == ADDR_FILT || a == ADDR_OTRP || a == ADDR_DTRP || a == ADDR_SENS;
  endfunction

  // axi write channel: address and data in either order
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_a = aw_a;
    next_w_d = w_d;
    next_w_s = w_s;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    wr_go = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_d = s_axi_wdata;
      next_w_s = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      wr_go = 1'b1;
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_a) ? 2'b00 : 2'b10;
    end
  end
  assign act_write = wr_go && aw_a == ADDR_CTRL && w_s[0] &&
    w_d[CTRL_ACTIVE];

  // axi read channel
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        ADDR_CTRL: next_rdata = ctrl;
        ADDR_STAT: next_rdata = stat;
        ADDR_MASK: next_rdata = mask;
        ADDR_FILT: next_rdata = filt;
        ADDR_OTRP: next_rdata = otrp;
        ADDR_DTRP: next_rdata = dtrp;
        ADDR_SENS: next_rdata = {24'h000000, 3'h0, ovp_on,
          st == BLFS_SHORT, 1'b0, dark_threshold_flag,
          office_threshold_flag};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register file, level ownership and sticky status
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_filt = filt;
    next_otrp = otrp;
    next_dtrp = dtrp;
    next_stat = stat;
    if (wr_go) begin
      unique case (aw_a)
        ADDR_CTRL: next_ctrl = wmerge(ctrl, w_d, w_s);
        ADDR_MASK: next_mask = wmerge(mask, w_d, w_s) & 32'h0000_0007;
        ADDR_FILT: next_filt = wmerge(filt, w_d, w_s) & 32'h0000_ffff;
        ADDR_OTRP: next_otrp = wmerge(otrp, w_d, w_s) & 32'h0000_ffff;
        ADDR_DTRP: next_dtrp = wmerge(dtrp, w_d, w_s) & 32'h0000_ffff;
        ADDR_STAT: begin
          if (w_s[0]) next_stat[2:0] = stat[2:0] & ~w_d[2:0];
        end
        default: ;
      endcase
    end
    // hardware sets win over a same-cycle clear
    if (ev_cmp) next_stat[ST_CMP] = 1'b1;
    if (ev_ovp) next_stat[ST_OVP] = 1'b1;
    if (ev_short) next_stat[ST_SHORT] = 1'b1;
    // auto mode owns the level field
    if (next_ctrl[CTRL_AUTO]) begin
      next_ctrl[CTRL_LVL +: 2] = next_level;
    end
    next_irq = |(next_stat[2:0] & next_mask[2:0]);
  end

  // level from flags, dark wins
  always_comb begin
    if (dark_threshold_flag) next_level = LVL_DARK;
    else if (office_threshold_flag) next_level = LVL_OFFICE;
    else next_level = LVL_DAY;
  end

  // hysteresis comparators on the sensor reading
  always_comb begin
    raw_office = office_threshold_flag;
    raw_dark = dark_threshold_flag;
    if (sensor_reading < otrp[7:0]) raw_office = 1'b1;
    else if ({1'b0, sensor_reading} > {1'b0, otrp[7:0]} +
      {1'b0, otrp[15:8]}) raw_office = 1'b0;
    if (sensor_reading < dtrp[7:0]) raw_dark = 1'b1;
    else if ({1'b0, sensor_reading} > {1'b0, dtrp[7:0]} +
      {1'b0, dtrp[15:8]}) raw_dark = 1'b0;
  end

  // filter: a changed comparator must persist for the filter time
  always_comb begin
    fwait = (32'(filt[7:0] % FILT_MAX_STEPS) + 32'd1) * 32'(STEP_CYC);
    next_office = office_threshold_flag;
    next_dark = dark_threshold_flag;
    next_fcnt_o = 32'h0000_0000;
    next_fcnt_d = 32'h0000_0000;
    if (raw_office != office_threshold_flag) begin
      next_fcnt_o = fcnt_o + 32'd1;
      if (next_fcnt_o >= fwait) begin
        next_office = raw_office;
        next_fcnt_o = 32'h0000_0000;
      end
    end
    if (raw_dark != dark_threshold_flag) begin
      next_fcnt_d = fcnt_d + 32'd1;
      if (next_fcnt_d >= fwait) begin
        next_dark = raw_dark;
        next_fcnt_d = 32'h0000_0000;
      end
    end
    ev_cmp = (next_office != office_threshold_flag) ||
      (next_dark != dark_threshold_flag);
  end

  // fault state machine: soft start, short mask, ovp, gain
  always_comb begin
    next_st = st;
    next_tcnt = tcnt;
    next_ovp_on = ovp_on;
    next_gain = pump_gain;
    ev_short = 1'b0;
    ev_ovp = 1'b0;
    unique case (st)
      BLFS_OFF: begin
        next_gain = GAIN_1X;
        if (ctrl[CTRL_ACTIVE]) begin
          next_st = BLFS_SOFT;
          next_tcnt = 32'h0000_0000;
        end
      end
      BLFS_SOFT, BLFS_RUN: begin
        if (tcnt < 32'(MASK_WAIT)) next_tcnt = tcnt + 32'd1;
        if (st == BLFS_SOFT && tcnt >= 32'(SOFT_WAIT)) next_st = BLFS_RUN;
        if (tcnt >= 32'(MASK_WAIT) && an.rail_low) begin
          next_st = BLFS_SHORT;
          ev_short = 1'b1;
        end
        // clamp regulation is analog and raises nothing
        if (!ovp_on && an.rail_ovp) begin
          next_ovp_on = 1'b1;
          ev_ovp = 1'b1;
        end else if (ovp_on && an.rail_ovp_rel) begin
          next_ovp_on = 1'b0;
        end
        if (|(sink_needs_gain & sink_enable)) begin
          if (pump_gain != GAIN_2X) next_gain = pump_gain + 2'h1;
        end else if (!ctrl[CTRL_GDB] && pump_gain != GAIN_1X) begin
          next_gain = pump_gain - 2'h1;
        end
        if (!ctrl[CTRL_ACTIVE]) next_st = BLFS_OFF;
      end
      BLFS_SHORT: begin
        next_ovp_on = 1'b0;
        next_gain = GAIN_1X;
        if (act_write) begin
          next_st = BLFS_SOFT;
          next_tcnt = 32'h0000_0000;
        end else if (!ctrl[CTRL_ACTIVE]) begin
          next_st = BLFS_OFF;
        end
      end
    endcase
    if (next_st == BLFS_OFF) next_ovp_on = 1'b0;
    next_pump = (next_st == BLFS_SOFT || next_st == BLFS_RUN) &&
      !next_ovp_on;
    next_sinks = next_st == BLFS_RUN;
    next_low = next_st == BLFS_SHORT || next_st == BLFS_OFF;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      stat <= 32'h0000_0000;
      mask <= 32'h0000_0000;
      filt <= FILT_RST;
      otrp <= TRP_RST;
      dtrp <= TRP_RST;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      office_threshold_flag <= 1'b0;
      dark_threshold_flag <= 1'b0;
      fcnt_o <= 32'h0000_0000;
      fcnt_d <= 32'h0000_0000;
      st <= BLFS_OFF;
      tcnt <= 32'h0000_0000;
      ovp_on <= 1'b0;
      pump_gain <= GAIN_1X;
      pump_enable <= 1'b0;
      sinks_enable <= 1'b0;
      low_current <= 1'b1;
      backlight_level_select <= LVL_DAY;
      irq <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      mask <= next_mask;
      filt <= next_filt;
      otrp <= next_otrp;
      dtrp <= next_dtrp;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_a <= next_aw_a;
      w_d <= next_w_d;
      w_s <= next_w_s;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_awready <= !next_aw_hold && !s_axi_awready;
      s_axi_wready <= !next_w_hold && !s_axi_wready;
      s_axi_arready <= !next_rvalid && !s_axi_arready;
      office_threshold_flag <= next_office;
      dark_threshold_flag <= next_dark;
      fcnt_o <= next_fcnt_o;
      fcnt_d <= next_fcnt_d;
      st <= next_st;
      tcnt <= next_tcnt;
      ovp_on <= next_ovp_on;
      pump_gain <= next_gain;
      pump_enable <= next_pump;
      sinks_enable <= next_sinks;
      low_current <= next_low;
      backlight_level_select <= next_ctrl[CTRL_LVL +: 2];
      irq <= next_irq;
    end
  end

  // checks
  sequence seq_ovp_entry;
    !ovp_on ##1 ovp_on;
  endsequence
  AST_AUTO_DARK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ce && ctrl[CTRL_AUTO] && dark_threshold_flag
    |=> (ctrl[CTRL_AUTO] |-> ctrl[CTRL_LVL +: 2] == LVL_DARK))
    else $error("dark flag did not force level 10");
  AST_AUTO_OFFICE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ctrl[CTRL_AUTO] && !dark_threshold_flag && office_threshold_flag
    && ce ##1 ce && ctrl[CTRL_AUTO] |-> ctrl[CTRL_LVL +: 2] == LVL_OFFICE)
    else $error("office level not selected");
  AST_OVP_FLAG: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_ovp_entry |-> stat[ST_OVP])
    else $error("ovp entry left flag clear");
  AST_OVP_PUMP: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ovp_on |-> !pump_enable)
    else $error("pump running in ovp");
  AST_SHORT_MASK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(st == BLFS_SHORT) |-> $past(tcnt) >= 32'(MASK_WAIT))
    else $error("short taken while masked");
  // flag and low current appear at the same edge as the state
  AST_SHORT_FLAG: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(st == BLFS_SHORT) |-> stat[ST_SHORT] && low_current)
    else $error("short entry without flag or low current");
  // off and short force 1x, so only steps inside soft or run count
  AST_GAIN_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ctrl[CTRL_GDB] && $past(ctrl[CTRL_GDB]) && st != BLFS_SHORT &&
    st != BLFS_OFF && $past(st) != BLFS_OFF && $past(st) != BLFS_SHORT
    |-> pump_gain >= $past(pump_gain))
    else $error("gain stepped down while blocked");
  AST_CLEAR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ce && wr_go && aw_a == ADDR_STAT && w_s[0] && w_d[ST_SHORT] && !ev_short
    |=> !stat[ST_SHORT])
    else $error("write one did not clear flag");
  AST_IRQ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ce ##1 ce |-> irq == |(stat[2:0] & mask[2:0]))
    else $error("irq does not follow masked status");
endmodule
`default_nettype wire
